// *** bit_shifter.sv ***
// Eight-bit MSB-first shift register with a bit counter.
`timescale 1ns/100ps
module bit_shifter (
    // Clock and reset.
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    // Control.
    input  wire logic       CLEAR_I,
    input  wire logic       LOAD_I,
    input  wire logic [7:0] LOAD_DATA_I,
    input  wire logic       SHIFT_I,
    input  wire logic       BIT_I,
    // State.
    output logic [7:0]      DATA_O,
    output logic [2:0]      COUNT_O
);

    import serial_port_pkg::*;

    logic [7:0] data_q;
    logic [2:0] count_q;

    // Load wins over shift; clear resets only the bit count.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            data_q  <= SHIFT_RESET;
            count_q <= 3'h0;
        end else if (LOAD_I) begin
            data_q  <= LOAD_DATA_I;
            count_q <= 3'h0;
        end else if (CLEAR_I) begin
            count_q <= 3'h0;
        end else if (SHIFT_I) begin
            data_q  <= {data_q[6:0], BIT_I};
            count_q <= count_q + 3'h1;
        end
    end

    assign DATA_O  = data_q;
    assign COUNT_O = count_q;

endmodule : bit_shifter

// *** bus_ctrl_model.sv ***
// Bus controller model that drives the clock and pulls the data line.
`timescale 1ns/100ps
module bus_ctrl_model (
    // Bus lines; the data line has a pull-up, so release reads high.
    output logic      SCL_O,
    output logic      SDA_LOW_O,
    input  wire logic SDA_I
);
    // Quarter bit time; the bench slows it for the fast standard rate.
    realtime q = 31.25;

    initial begin
        SCL_O = 1'b1;
        SDA_LOW_O = 1'b0;
    end

    // pull low only, change while clock low.
    task automatic slot(input logic d, output logic s);
        #q;
        SDA_LOW_O = !d;
        #q;
        SCL_O = 1'b1;
        #q;
        s = SDA_I;
        #q;
        SCL_O = 1'b0;
    endtask : slot

    task automatic start();
        #q;
        SDA_LOW_O = 1'b0;
        #q;
        SCL_O = 1'b1;
        #q;
        SDA_LOW_O = 1'b1;
        #q;
        SCL_O = 1'b0;
    endtask : start

    task automatic stop();
        #q;
        SDA_LOW_O = 1'b1;
        #q;
        SCL_O = 1'b1;
        #q;
        SDA_LOW_O = 1'b0;
        #q;
    endtask : stop

    // most significant bit first, then the answer bit.
    task automatic put_byte(input logic [7:0] b, output logic nack);
        for (int i = 7; i >= 0; i--) begin
            slot(b[i], nack);
        end
        slot(1'b1, nack);
    endtask : put_byte

    // acknowledge all but the last byte read.
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, b[i]);
        end
        slot(last, s);
    endtask : get_byte
endmodule : bus_ctrl_model

// *** line_sync.sv ***
// Two-flop synchroniser with edge detection for one bus line.
`timescale 1ns/100ps
module line_sync (
    // Clock and reset.
    input  wire logic CLK_I,
    input  wire logic RST_I,
    // Raw line and synchronised views.
    input  wire logic LINE_I,
    output logic      LEVEL_O,
    output logic      RISE_O,
    output logic      FALL_O
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // The first flop feeds only the second; edges come from later stages.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= LINE_I;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Level and one-cycle edge pulses.
    assign LEVEL_O = sync_q;
    assign RISE_O  = sync_q & ~prev_q;
    assign FALL_O  = ~sync_q & prev_q;

endmodule : line_sync

// *** serial_port_pkg.sv ***
// Shared constants for the two-wire target register port.
package serial_port_pkg;

    // Bus address: base seven-bit address when both select pins are low.
    localparam logic [6:0] BASE_ADDR7      = 7'h6A;
    localparam int         BYTE_BITS       = 8;
    localparam logic [2:0] LAST_BIT_INDEX  = 3'h7;

    // Core clock and the slowest and fastest supported bus rates.
    localparam int CORE_CLK_HZ  = 100_000_000;
    localparam int RATE_STD_BPS = 100_000;
    localparam int RATE_FAST_BPS = 400_000;

    // Serial clock period at the fast rate, in core cycles (rounded down).
    localparam int FAST_BIT_CYCLES = CORE_CLK_HZ / RATE_FAST_BPS;

    // Register pointer and data widths of the internal path.
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 8;

    // Reset values.
    localparam logic [7:0] PTR_RESET   = 8'h00;
    localparam logic [7:0] SHIFT_RESET = 8'h00;

    // Transfer phases.
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WR_BYTE  = 3'b011,
        ST_WR_ACK   = 3'b100,
        ST_RD_BYTE  = 3'b101,
        ST_RD_ACK   = 3'b110
    } phase_e;

endpackage : serial_port_pkg

// *** serial_target_port.sv ***
// Two-wire target-only port giving byte access to internal registers.
//
// What this block does
// - Pins select address 0xD4 plus two per step, up to 0xDA.
// - Works at 100 kbps and 400 kbps for all transfer kinds.
// - Target only: never starts transfers, arbitrates or stretches clock.
// - Bytes are eight bits, most significant bit first.
// - Data falling while clock high is start; rising is stop.
// - Driven data changes only while the clock line is low.
// - Acknowledge each received byte by holding data low in ninth period.
// - First byte is seven-bit address then direction, zero write.
// - Write: address, register address, data, each acknowledged, then stop.
// - Each written data byte is written and the pointer increments before its acknowledge.
// - Read follows register address write, repeated start, read direction.
// - On not-acknowledge of read byte, release the data line.
// - Controller acks all read bytes but last; pointer steps each byte.
// - No limit on data bytes between start and stop.
// - Lines only pulled low or released; pull-ups give high.
`timescale 1ns/100ps
module serial_target_port (
    // Core clock and reset.
    input  wire logic                                CORE_CLK_I,
    input  wire logic                                RST_I,
    // Address select straps.
    input  wire logic                                ADDRESS_SELECT_LOW_PIN_I,
    input  wire logic                                ADDRESS_SELECT_HIGH_PIN_I,
    // Serial clock line, input only since the clock is never stretched.
    input  wire logic                                SCL_I,
    // Serial data line as input, output and enable.
    input  wire logic                                SDA_I,
    output logic                                     SDA_O,
    output logic                                     SDA_OE_O,
    // Internal register path.
    output logic [serial_port_pkg::REG_ADDR_W-1:0]   REG_ADDR_O,
    output logic [serial_port_pkg::REG_DATA_W-1:0]   REG_WDATA_O,
    output logic                                     REG_WRITE_O,
    output logic                                     REG_READ_O,
    input  wire logic [serial_port_pkg::REG_DATA_W-1:0] REG_RDATA_I,
    // Transfer status.
    output logic                                     BUSY_O
);

    import serial_port_pkg::*;

    // Synchronised lines and their edges.
    logic       scl_lvl;
    logic       scl_rise;
    logic       scl_fall;
    logic       sda_lvl;
    logic       sda_rise;
    logic       sda_fall;

    // Shift register view.
    logic [7:0] shift_data;
    logic [2:0] shift_count;

    // State.
    phase_e     phase_q;
    phase_e     phase_d;
    logic [7:0] ptr_q;
    logic       ack_half_q;
    logic       sda_drive_q;
    logic       sda_drive_d;
    logic       first_wr_q;
    logic       rd_nack_q;
    logic       wr_pulse_q;
    logic       rd_pulse_q;
    logic [7:0] wdata_q;
    logic [1:0] sel_meta_q;
    logic [1:0] sel_q;
    logic       busy_q;

    // Both bus lines pass two flops before any logic reads them.
    // many samples per bit
    line_sync u_scl_sync (
        .CLK_I   (CORE_CLK_I),
        .RST_I   (RST_I),
        .LINE_I  (SCL_I),
        .LEVEL_O (scl_lvl),
        .RISE_O  (scl_rise),
        .FALL_O  (scl_fall)
    );

    line_sync u_sda_sync (
        .CLK_I   (CORE_CLK_I),
        .RST_I   (RST_I),
        .LINE_I  (SDA_I),
        .LEVEL_O (sda_lvl),
        .RISE_O  (sda_rise),
        .FALL_O  (sda_fall)
    );

    wire start_cond = sda_fall & scl_lvl;
    wire stop_cond  = sda_rise & scl_lvl;

    // Straps pass two flops; the second loads only while idle, so a
    // change in mid-transfer cannot alter the address being matched.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sel_meta_q <= 2'b00;
            sel_q      <= 2'b00;
        end else begin
            sel_meta_q <= {ADDRESS_SELECT_HIGH_PIN_I,
                           ADDRESS_SELECT_LOW_PIN_I};
            if (phase_q == ST_IDLE) begin
                sel_q <= sel_meta_q;
            end
        end
    end

    wire [6:0] own_addr  = BASE_ADDR7 + {5'b00000, sel_q};
    wire       addr_hit  = (shift_data[6:0] == own_addr); // At eighth rise.
    wire       dir_read  = shift_data[0];

    // Byte boundary: eighth bit sampled on this rising edge.
    wire       byte_done = scl_rise & (shift_count == LAST_BIT_INDEX);
    wire       in_byte   = (phase_q == ST_ADDR) | (phase_q == ST_WR_BYTE);
    wire       do_shift  = scl_rise & in_byte & ~start_cond & ~stop_cond;
    wire       in_ack    = (phase_q == ST_ADDR_ACK) | (phase_q == ST_WR_ACK);
    wire       first_rd_low = dir_read & ~REG_RDATA_I[7];
    // drive after falling; reload for next read byte
    wire       rd_load   = scl_fall & (phase_q == ST_ADDR_ACK) & dir_read
                           & ack_half_q;
    wire       rd_next   = scl_fall & (phase_q == ST_RD_ACK) & ~rd_nack_q;
    wire       do_load   = rd_load | rd_next;
    wire       rd_shift  = scl_fall & (phase_q == ST_RD_BYTE)
                           & (shift_count != LAST_BIT_INDEX);
    wire       do_clear  = start_cond | (scl_fall & (phase_q == ST_WR_ACK))
                           | (scl_fall & (phase_q == ST_ADDR_ACK) & ~dir_read);

    bit_shifter u_shift (
        .CLK_I       (CORE_CLK_I),
        .RST_I       (RST_I),
        .CLEAR_I     (do_clear),
        .LOAD_I      (do_load),
        .LOAD_DATA_I (REG_RDATA_I),
        .SHIFT_I     (do_shift | rd_shift),
        .BIT_I       (sda_lvl),
        .DATA_O      (shift_data),
        .COUNT_O     (shift_count)
    );

    // Phase sequencing, driven by start, stop and bus clock edges.
    always_comb begin
        phase_d = phase_q;
        if (start_cond) begin
            phase_d = ST_ADDR;
        end else if (stop_cond) begin
            phase_d = ST_IDLE;
        end else begin
            case (phase_q)
                ST_IDLE: begin
                    phase_d = ST_IDLE;
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        phase_d = addr_hit ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall && ack_half_q) begin
                        phase_d = dir_read ? ST_RD_BYTE : ST_WR_BYTE;
                    end
                end
                ST_WR_BYTE: begin
                    if (byte_done) begin
                        phase_d = ST_WR_ACK;
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall && ack_half_q) begin
                        phase_d = ST_WR_BYTE;
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_fall && shift_count == LAST_BIT_INDEX) begin
                        phase_d = ST_RD_ACK;
                    end
                end
                ST_RD_ACK: begin
                    if (scl_fall) begin
                        phase_d = rd_nack_q ? ST_IDLE : ST_RD_BYTE;
                    end
                end
                default: begin
                    phase_d = ST_IDLE;
                end
            endcase
        end
    end

    // acknowledge and read data drive; changes on falling edges, cleared by start or stop
    always_comb begin
        sda_drive_d = sda_drive_q;
        if (start_cond | stop_cond) begin
            sda_drive_d = 1'b0;
        end else if (scl_fall) begin
            case (phase_q)
                ST_ADDR:     sda_drive_d = 1'b0;
                ST_WR_BYTE:  sda_drive_d = 1'b0;
                ST_ADDR_ACK: sda_drive_d = ack_half_q ? first_rd_low : 1'b1;
                ST_WR_ACK:   sda_drive_d = ~ack_half_q;
                ST_RD_BYTE:  sda_drive_d = (shift_count == LAST_BIT_INDEX)
                                           ? 1'b0 : ~shift_data[6];
                ST_RD_ACK:   sda_drive_d = ~rd_nack_q & ~REG_RDATA_I[7];
                default:     sda_drive_d = 1'b0;
            endcase
        end
    end

    // Main state registers.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            phase_q     <= ST_IDLE;
            sda_drive_q <= 1'b0;
            busy_q      <= 1'b0;
        end else begin
            phase_q     <= phase_d;
            sda_drive_q <= sda_drive_d;
            busy_q      <= start_cond | (busy_q & ~stop_cond);
        end
    end

    // An ack clock spans two falls: the one ending the eighth bit starts
    // the drive and the next one ends it, so this flag tells them apart.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ack_half_q <= 1'b0;
        end else if (start_cond | stop_cond) begin
            ack_half_q <= 1'b0;
        end else if (scl_fall & in_ack) begin
            ack_half_q <= ~ack_half_q;
        end
    end

    // capture controller acknowledge on the ninth rising edge
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rd_nack_q <= 1'b0;
        end else if (scl_rise && phase_q == ST_RD_ACK) begin
            rd_nack_q <= sda_lvl;
        end
    end

    // first written byte is the register pointer
    // pointer advances after each written data byte
    // pointer advances after each read byte
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ptr_q      <= PTR_RESET;
            first_wr_q <= 1'b0;
            wdata_q    <= SHIFT_RESET;
            wr_pulse_q <= 1'b0;
            rd_pulse_q <= 1'b0;
        end else begin
            wr_pulse_q <= 1'b0;
            rd_pulse_q <= do_load;
            if (start_cond) begin
                first_wr_q <= 1'b1;
            end
            if (wr_pulse_q) begin
                ptr_q <= ptr_q + 8'h01;
            end
            if (rd_pulse_q) begin
                ptr_q <= ptr_q + 8'h01;
            end
            if (byte_done && phase_q == ST_WR_BYTE && !stop_cond) begin
                if (first_wr_q) begin
                    ptr_q      <= {shift_data[6:0], sda_lvl};
                    first_wr_q <= 1'b0;
                end else begin
                    wdata_q    <= {shift_data[6:0], sda_lvl};
                    wr_pulse_q <= 1'b1;
                end
            end
            if (phase_q == ST_ADDR_ACK && dir_read) begin
                first_wr_q <= 1'b0;
            end
        end
    end

    // open drain: only pull low or release
    assign SDA_O       = 1'b0;
    assign SDA_OE_O    = sda_drive_q & busy_q;
    assign REG_ADDR_O  = ptr_q;
    assign REG_WDATA_O = wdata_q;
    assign REG_WRITE_O = wr_pulse_q;
    assign REG_READ_O  = rd_pulse_q;
    assign BUSY_O      = busy_q;

endmodule : serial_target_port

// *** serial_target_port_chk.sv ***
// Concurrent checks on the two-wire target port's pins.
`timescale 1ns/100ps
module serial_target_port_chk (
    // Clock and reset.
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // Bus lines.
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    // Register path and status.
    input wire logic [serial_port_pkg::REG_ADDR_W-1:0] REG_ADDR_O,
    input wire logic REG_WRITE_O,
    input wire logic REG_READ_O,
    input wire logic BUSY_O
);
    logic [7:0] ptr_q;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);

    // Pointer held at the last register access, for the step check.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ptr_q <= 8'h00;
        end else if (REG_WRITE_O || REG_READ_O) begin
            ptr_q <= REG_ADDR_O;
        end
    end

    // Bus conditions and the end of a written byte.
    sequence s_start;
        SCL_I && $fell(SDA_I);
    endsequence
    sequence s_stop;
        SCL_I && $rose(SDA_I);
    endsequence
    sequence s_byte_end;
        first_match(REG_WRITE_O ##[1:200] $fell(SCL_I));
    endsequence

    a_low_only: assert property (SDA_OE_O |-> !SDA_O)
        else $error("data line driven high");
    a_idle_release: assert property (!BUSY_O |-> !SDA_OE_O)
        else $error("data line driven outside a transfer");
    // Raw clock is low whenever the drive changes, so data is stable high.
    a_edge_timing: assert property ($changed(SDA_OE_O) |-> !SCL_I)
        else $error("data drive changed while clock high");
    a_write_pulse: assert property (REG_WRITE_O |=> !REG_WRITE_O)
        else $error("write pulse longer than one cycle");
    a_read_pulse: assert property (REG_READ_O |=> !REG_READ_O)
        else $error("read pulse longer than one cycle");
    a_ptr_step: assert property ((REG_WRITE_O || REG_READ_O) |=>
        ##[0:8] REG_ADDR_O == ptr_q + 8'h01)
        else $error("pointer did not step by one");
    a_ack_drive: assert property (s_byte_end |-> ##[1:8] SDA_OE_O)
        else $error("received byte not acknowledged");
    a_start_busy: assert property (s_start |-> ##[1:8] BUSY_O)
        else $error("start not seen");
    a_stop_idle: assert property (s_stop |-> ##[1:8] !BUSY_O)
        else $error("stop not seen");
endmodule : serial_target_port_chk

bind serial_target_port serial_target_port_chk chk (.CORE_CLK_I, .RST_I,
    .SCL_I, .SDA_I, .SDA_O, .SDA_OE_O, .REG_ADDR_O, .REG_WRITE_O,
    .REG_READ_O, .BUSY_O);

// *** serial_target_port_tb.sv ***
// Self-checking bench for the two-wire target register port.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module serial_target_port_tb;
    import serial_port_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  pins = 2'b00;
    logic        scl;
    logic        ctl_low;
    logic        sda_oe;
    logic        sda_o;
    logic        reg_wr;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  dut_mem [256];
    logic [7:0]  exp_mem [256];
    logic [31:0] lfsr = 32'h2fc9_403e;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    // Wired-AND data line with its pull-up.
    wire         sda = !(ctl_low || (sda_oe && !sda_o));

    always #5 clk = !clk;

    bus_ctrl_model m (.SCL_O(scl), .SDA_LOW_O(ctl_low), .SDA_I(sda));

    serial_target_port uut (.CORE_CLK_I(clk), .RST_I(rst),
        .ADDRESS_SELECT_LOW_PIN_I(pins[0]),
        .ADDRESS_SELECT_HIGH_PIN_I(pins[1]), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE_O(sda_oe), .REG_ADDR_O(reg_addr),
        .REG_WDATA_O(reg_wdata), .REG_WRITE_O(reg_wr), .REG_READ_O(),
        .REG_RDATA_I(dut_mem[reg_addr]), .BUSY_O());

    // Register map stand-in, filled during reset, then written by the pulse.
    always @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 256; i++) begin
                dut_mem[i] <= 8'(i);
            end
        end else if (reg_wr) begin
            dut_mem[reg_addr] <= reg_wdata;
        end
    end

    // Hang guard well above the slow pass of about 31000 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            give_verdict();
        end
    end

    function automatic logic [31:0] next_rnd(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : next_rnd

    task automatic send(input logic [7:0] b, input logic e);
        logic a;
        m.put_byte(b, a);
        `CHK("answer bit", e, a)
    endtask : send

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        logic [7:0] p;
        logic [7:0] d;
        logic [7:0] aw;
        for (int i = 0; i < 256; i++) begin
            exp_mem[i] = 8'(i);
        end
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            #1 pins = 2'(k);
            // Third pass runs at the 400 kbps rate, the rest on the link.
            m.q = (k == 2) ? 625.0 : 31.25;
            aw = 8'hd4 + 8'(2 * k);
            lfsr = next_rnd(lfsr);
            // Last pass starts at the top so the pointer wraps.
            p = (k == 3) ? 8'hff : lfsr[7:0];
            m.start();
            send(aw, 1'b0);
            send(p, 1'b0);
            for (int j = 0; j < 2; j++) begin
                d = lfsr[15 + 8 * j -: 8];
                send(d, 1'b0);
                exp_mem[8'(p + j)] = d;
            end
            m.stop();
            // A neighbour's address must be ignored entirely.
            m.start();
            send(8'hd4 + 8'(2 * ((k + 1) % 4)), 1'b1);
            send(p, 1'b1);
            send(~d, 1'b1);
            m.stop();
            m.start();
            send(aw, 1'b0);
            send(p, 1'b0);
            m.start();
            send(aw | 8'h01, 1'b0);
            for (int j = 0; j < 3; j++) begin
                m.get_byte(j == 2, d);
                `CHK("read data", exp_mem[8'(p + j)], d)
            end
            m.stop();
            for (int i = 0; i < 256; i++) begin
                `CHK("register", exp_mem[i], dut_mem[i])
            end
        end
        give_verdict();
    end
endmodule : serial_target_port_tb
